// ==== design/iosr_regs.vh ====
`ifndef IOSR_REGS_VH
`define IOSR_REGS_VH
// ****************************************
// io address map
// ****************************************
`define IOSR_A_FLAGS 6'h00
`define IOSR_A_SP 6'h02
`define IOSR_A_CLKMD 6'h03
`define IOSR_A_INTEN 6'h04
`define IOSR_A_INTRQ 6'h05
`define IOSR_A_TMODE 6'h06
`define IOSR_A_BGPC 6'h0a
`define IOSR_A_TRIM 6'h0b
`define IOSR_A_EDGE 6'h0c
`define IOSR_A_WAKE 6'h0d
`define IOSR_A_PDATA 6'h10
`define IOSR_A_PDIR 6'h11
`define IOSR_A_PPULL 6'h12
`define IOSR_A_MISC 6'h3b
// ****************************************
// reset values
// ****************************************
`define IOSR_RST_ZERO 8'h00
`define IOSR_RST_CLKMD 8'hf6
`define IOSR_RST_WAKE 8'hf9
`define IOSR_RST_PC 10'h000
// ****************************************
// field masks and positions
// ****************************************
`define IOSR_FLAGS_HI 4'hf
`define IOSR_INT_MASK 8'h05
`define IOSR_TRIM_MASK 8'h3f
`define IOSR_EDGE_MASK 8'h13
`define IOSR_WAKE_MASK 8'hf9
`define IOSR_MISC_MASK 8'h2f
`define IOSR_BGPC_MASK 8'h01
`define IOSR_SP_MASK 8'hfe
`define IOSR_PIN_OD 5
`define IOSR_PIN_INT 0
`define IOSR_BIT_TMR 2
`define IOSR_BIT_PIN0 0
`define IOSR_BIT_FAST 4
`define IOSR_BIT_TYPE 3
`define IOSR_BIT_SLOW 2
`define IOSR_BIT_WDOG 1
`define IOSR_BIT_RSTP 0
`define IOSR_BIT_TEDGE 4
`define IOSR_BIT_FASTWK 5
// ****************************************
// encodings
// ****************************************
`define IOSR_SRC_OFF 3'h0
`define IOSR_SRC_SYS 3'h1
`define IOSR_SRC_FAST 3'h4
`define IOSR_SRC_SLOW 3'h6
`define IOSR_SRC_PIN 3'h7
`define IOSR_EDGE_BOTH 2'h0
`define IOSR_EDGE_RISE 2'h1
`define IOSR_EDGE_FALL 2'h2
`define IOSR_CK_FAST4 4'h0
`define IOSR_CK_FAST2 4'h1
`define IOSR_CK_SLOW4 4'h6
`define IOSR_CK_SLOW1 4'h7
`define IOSR_CK_FAST16 4'h8
`define IOSR_CK_FAST8 4'h9
`define IOSR_CK_FAST32 4'hb
`define IOSR_CK_FAST64 4'hc
`define IOSR_WDT_2048 16'd2048
`define IOSR_WDT_4096 16'd4096
`define IOSR_WDT_16384 16'd16384
`define IOSR_WDT_256 16'd256
`define IOSR_WAKE_NORMAL 11'd1024
`define IOSR_WAKE_FAST 11'd128
`define IOSR_PRE_1 6'h00
`define IOSR_PRE_4 6'h03
`define IOSR_PRE_16 6'h0f
`define IOSR_PRE_64 6'h3f
`endif

// ==== design/iosr_pad.v ====
`timescale 1ns/1ps
`include "iosr_regs.vh"
// ****************************************
// one port pad control slice
// ****************************************
module iosr_pad #(
    parameter HAS_HIGH = 1
) (
    data_bit,
    dir_bit,
    pull_bit,
    pad_in,
    pad_out,
    pad_oe_n,
    pull_on,
    read_bit
);
    input wire data_bit;
    input wire dir_bit;
    input wire pull_bit;
    input wire pad_in;
    output wire pad_out;
    output wire pad_oe_n;
    output wire pull_on;
    output wire read_bit;
    // drive value: open drain pin only ever drives low
    assign pad_out = HAS_HIGH ? data_bit : 1'b0;
    // enable low while driving; open drain floats on a high bit
    assign pad_oe_n = ~(dir_bit & (HAS_HIGH ? 1'b1 : ~data_bit));
    // pull-up only for input or output-high; off when driving low
    assign pull_on = (HAS_HIGH != 0) & pull_bit & (~dir_bit | data_bit);
    // output pins read back the latch, inputs read the pad
    assign read_bit = dir_bit ? data_bit : pad_in;
endmodule

// ==== design/iosr_top.v ====
`timescale 1ns/1ps
`include "iosr_regs.vh"
module iosr_top (
    clk,
    rst_n,
    io_addr,
    io_wr,
    io_rd,
    io_wdata,
    io_rdata,
    alu_flags_in,
    alu_flags_we,
    alu_flags_out,
    sleep_save,
    sleep_deep,
    timer_count,
    pad_in,
    pad_out,
    pad_oe_n,
    pull_on,
    ext_reset_sel,
    reset_vector,
    irq_timer,
    irq_pin,
    wake_event,
    clk_sel_code,
    clk_sel_valid,
    fast_osc_en,
    slow_osc_en,
    wdog_en,
    fast_osc_trim,
    bandgap_off,
    lvr_disable,
    timer_src,
    timer_tick_en,
    timer_prescale_max,
    wdog_timeout,
    wake_count
);
    input wire clk;
    input wire rst_n;
    input wire [5:0] io_addr; // io space address
    input wire io_wr; // write strobe, one cycle
    input wire io_rd; // read strobe
    input wire [7:0] io_wdata;
    output reg [7:0] io_rdata; // registered read data
    input wire [3:0] alu_flags_in; // flags from the alu
    input wire alu_flags_we; // alu updates flags
    output wire [3:0] alu_flags_out;
    input wire sleep_save; // core in power-save sleep
    input wire sleep_deep; // core in power-down sleep
    input wire [15:0] timer_count; // timer counter value
    input wire [7:0] pad_in;
    output wire [7:0] pad_out;
    output wire [7:0] pad_oe_n;
    output wire [7:0] pull_on;
    output wire ext_reset_sel; // pin 5 used as reset input
    output wire [9:0] reset_vector; // restart address
    output wire irq_timer; // timer request and enabled
    output wire irq_pin; // pin 0 request and enabled
    output reg wake_event; // wake-up pulse
    output wire [3:0] clk_sel_code; // {type, bits 7:5}
    output wire clk_sel_valid; // code is not reserved
    output wire fast_osc_en;
    output wire slow_osc_en;
    output wire wdog_en;
    output wire [5:0] fast_osc_trim;
    output wire bandgap_off;
    output wire lvr_disable;
    output wire [2:0] timer_src;
    output wire timer_tick_en; // source not off and not reserved
    output reg [5:0] timer_prescale_max; // prescaler terminal count
    output reg [15:0] wdog_timeout; // slow clocks
    output wire [10:0] wake_count; // wake-up delay count
    // ****************************************
    // register storage
    // ****************************************
    reg [3:0] flags_q; // alu flags
    reg [7:0] sp_q; // stack pointer
    reg [7:0] clkmd_q; // clock mode
    reg [7:0] inten_q; // interrupt enables
    reg [7:0] intrq_q; // interrupt requests
    reg [7:0] tmode_q; // timer mode
    reg [7:0] bgpc_q; // bandgap power control
    reg [7:0] trim_q; // oscillator trim
    reg [7:0] edge_q; // edge select
    reg [7:0] wake_q; // input and wake enables
    reg [7:0] pdata_q; // port data latch
    reg [7:0] pdir_q; // port direction
    reg [7:0] ppull_q; // pull-up enables
    reg [7:0] misc_q; // wake and watchdog control
    reg [7:0] pad_last_q; // previous pad levels
    reg tbit_last_q; // previous selected counter bit
    reg [7:0] rdata_d; // read mux
    reg [7:0] intrq_d; // request next value
    wire [7:0] read_bits; // per pin read value
    wire [7:0] pad_chg; // toggled pads
    wire pin_rise; // pin 0 rising edge
    wire pin_fall; // pin 0 falling edge
    wire pin_evt; // pin 0 interrupt event
    wire tbit; // selected counter bit
    wire tmr_evt; // timer interrupt event
    wire wr_intrq; // software write to requests
    // ****************************************
    // pad slices
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pad
            iosr_pad #(
                .HAS_HIGH(gi == `IOSR_PIN_OD ? 0 : 1)
            ) u_pad (
                .data_bit(pdata_q[gi]),
                .dir_bit(pdir_q[gi]),
                .pull_bit(ppull_q[gi]),
                .pad_in(pad_in[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe_n(pad_oe_n[gi]),
                .pull_on(pull_on[gi]),
                .read_bit(read_bits[gi])
            );
        end
    endgenerate
    // ****************************************
    // event detection
    // ****************************************
    // pin 0 edges only count while its input is enabled
    assign pin_rise = pad_in[`IOSR_PIN_INT] & ~pad_last_q[`IOSR_PIN_INT];
    assign pin_fall = ~pad_in[`IOSR_PIN_INT] & pad_last_q[`IOSR_PIN_INT];
    assign pin_evt = wake_q[`IOSR_PIN_INT] &
        ((edge_q[1:0] == `IOSR_EDGE_BOTH & (pin_rise | pin_fall)) |
        (edge_q[1:0] == `IOSR_EDGE_RISE & pin_rise) |
        (edge_q[1:0] == `IOSR_EDGE_FALL & pin_fall));
    // counter bit 8 plus the select code
    assign tbit = timer_count[{1'b1, tmode_q[2:0]}];
    assign tmr_evt = edge_q[`IOSR_BIT_TEDGE] ? (tbit_last_q & ~tbit) :
        (~tbit_last_q & tbit);
    assign pad_chg = (pad_in ^ pad_last_q) & wake_q;
    assign wr_intrq = io_wr & (io_addr == `IOSR_A_INTRQ);
    // ****************************************
    // request next value: set wins over clear
    // ****************************************
    always @* begin
        intrq_d = intrq_q;
        if (wr_intrq) begin
            intrq_d = io_wdata & `IOSR_INT_MASK;
        end
        if (tmr_evt) begin
            intrq_d[`IOSR_BIT_TMR] = 1'b1;
        end
        if (pin_evt) begin
            intrq_d[`IOSR_BIT_PIN0] = 1'b1;
        end
    end
    // ****************************************
    // register writes
    // ****************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= 4'h0;
            sp_q <= `IOSR_RST_ZERO;
            clkmd_q <= `IOSR_RST_CLKMD;
            inten_q <= `IOSR_RST_ZERO;
            intrq_q <= `IOSR_RST_ZERO;
            tmode_q <= `IOSR_RST_ZERO;
            bgpc_q <= `IOSR_RST_ZERO;
            trim_q <= `IOSR_RST_ZERO;
            edge_q <= `IOSR_RST_ZERO;
            wake_q <= `IOSR_RST_WAKE;
            pdata_q <= `IOSR_RST_ZERO;
            pdir_q <= `IOSR_RST_ZERO;
            ppull_q <= `IOSR_RST_ZERO;
            misc_q <= `IOSR_RST_ZERO;
            pad_last_q <= `IOSR_RST_ZERO;
            tbit_last_q <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            pad_last_q <= pad_in;
            tbit_last_q <= tbit;
            intrq_q <= intrq_d;
            // pin toggles wake from either sleep; timer only from save
            wake_event <= (|pad_chg & (sleep_save | sleep_deep)) |
                (tmr_evt & sleep_save);
            if (alu_flags_we) begin
                flags_q <= alu_flags_in;
            end
            // io writes take effect on this edge
            if (io_wr) begin
                case (io_addr)
                    `IOSR_A_FLAGS: flags_q <= io_wdata[3:0];
                    `IOSR_A_SP: sp_q <= io_wdata;
                    `IOSR_A_CLKMD: clkmd_q <= io_wdata;
                    `IOSR_A_INTEN: inten_q <= io_wdata & `IOSR_INT_MASK;
                    `IOSR_A_TMODE: tmode_q <= io_wdata;
                    `IOSR_A_BGPC: bgpc_q <= io_wdata & `IOSR_BGPC_MASK;
                    `IOSR_A_TRIM: trim_q <= io_wdata & `IOSR_TRIM_MASK;
                    `IOSR_A_EDGE: edge_q <= io_wdata & `IOSR_EDGE_MASK;
                    `IOSR_A_WAKE: wake_q <= io_wdata & `IOSR_WAKE_MASK;
                    `IOSR_A_PDATA: pdata_q <= io_wdata;
                    `IOSR_A_PDIR: pdir_q <= io_wdata;
                    `IOSR_A_PPULL: ppull_q <= io_wdata;
                    `IOSR_A_MISC: misc_q <= io_wdata & `IOSR_MISC_MASK;
                    default: ;
                endcase
            end
        end
    end
    // ****************************************
    // read mux
    // ****************************************
    always @* begin
        case (io_addr)
            `IOSR_A_FLAGS: rdata_d = {`IOSR_FLAGS_HI, flags_q};
            `IOSR_A_SP: rdata_d = sp_q;
            `IOSR_A_CLKMD: rdata_d = clkmd_q;
            `IOSR_A_INTEN: rdata_d = inten_q;
            `IOSR_A_INTRQ: rdata_d = intrq_q;
            `IOSR_A_TMODE: rdata_d = tmode_q;
            `IOSR_A_PDATA: rdata_d = read_bits;
            `IOSR_A_PDIR: rdata_d = pdir_q;
            `IOSR_A_PPULL: rdata_d = ppull_q;
            default: rdata_d = `IOSR_RST_ZERO;
        endcase
    end
    // registered read data, held between reads
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= `IOSR_RST_ZERO;
        end else if (io_rd) begin
            io_rdata <= rdata_d;
        end
    end
    // ****************************************
    // decoded settings
    // ****************************************
    always @* begin
        case (tmode_q[4:3])
            2'h0: timer_prescale_max = `IOSR_PRE_1;
            2'h1: timer_prescale_max = `IOSR_PRE_4;
            2'h2: timer_prescale_max = `IOSR_PRE_16;
            default: timer_prescale_max = `IOSR_PRE_64;
        endcase
    end
    always @* begin
        case (misc_q[1:0])
            2'h0: wdog_timeout = `IOSR_WDT_2048;
            2'h1: wdog_timeout = `IOSR_WDT_4096;
            2'h2: wdog_timeout = `IOSR_WDT_16384;
            default: wdog_timeout = `IOSR_WDT_256;
        endcase
    end
    assign alu_flags_out = flags_q;
    assign irq_timer = intrq_q[`IOSR_BIT_TMR] & inten_q[`IOSR_BIT_TMR];
    assign irq_pin = intrq_q[`IOSR_BIT_PIN0] & inten_q[`IOSR_BIT_PIN0];
    assign ext_reset_sel = clkmd_q[`IOSR_BIT_RSTP];
    assign reset_vector = `IOSR_RST_PC;
    assign clk_sel_code = {clkmd_q[`IOSR_BIT_TYPE], clkmd_q[7:5]};
    assign clk_sel_valid = (clk_sel_code == `IOSR_CK_FAST4) |
        (clk_sel_code == `IOSR_CK_FAST2) | (clk_sel_code == `IOSR_CK_SLOW4) |
        (clk_sel_code == `IOSR_CK_SLOW1) | (clk_sel_code == `IOSR_CK_FAST16) |
        (clk_sel_code == `IOSR_CK_FAST8) | (clk_sel_code == `IOSR_CK_FAST32) |
        (clk_sel_code == `IOSR_CK_FAST64);
    assign fast_osc_en = clkmd_q[`IOSR_BIT_FAST];
    assign slow_osc_en = clkmd_q[`IOSR_BIT_SLOW];
    assign wdog_en = clkmd_q[`IOSR_BIT_WDOG] & clkmd_q[`IOSR_BIT_SLOW];
    assign fast_osc_trim = trim_q[5:0];
    assign bandgap_off = bgpc_q[0];
    assign lvr_disable = misc_q[2];
    assign timer_src = tmode_q[7:5];
    assign timer_tick_en = (timer_src == `IOSR_SRC_SYS) | (timer_src == `IOSR_SRC_FAST) |
        (timer_src == `IOSR_SRC_SLOW) | (timer_src == `IOSR_SRC_PIN);
    assign wake_count = misc_q[`IOSR_BIT_FASTWK] ? `IOSR_WAKE_FAST :
        `IOSR_WAKE_NORMAL;
endmodule

// ==== bench/iosr_checker.sv ====
`timescale 1ns/1ps
`include "iosr_regs.vh"
// ****************************************
// port-level checks of the register bank
// ****************************************
module iosr_checker (
    input wire clk,
    input wire rst_n,
    input wire [5:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe_n,
    input wire [7:0] pull_on,
    input wire [9:0] reset_vector,
    input wire irq_pin,
    input wire slow_osc_en,
    input wire wdog_en,
    input wire [5:0] timer_prescale_max,
    input wire [10:0] wake_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a direction write taken at this edge
    sequence s_dir_wr;
        io_wr && io_addr == `IOSR_A_PDIR;
    endsequence
    // a timer mode write asking for divide by 64
    sequence s_pre64_wr;
        io_wr && io_addr == `IOSR_A_TMODE && io_wdata[4:3] == 2'b11;
    endsequence
    AST_DIR_TAKES: assert property (s_dir_wr |=>
        ((~pad_oe_n) & 8'hdf) == ($past(io_wdata) & 8'hdf))
        else $error("direction write not seen on output enables");
    AST_PIN5_OPEN_DRAIN: assert property (!(!pad_oe_n[5] && pad_out[5]) && !pull_on[5])
        else $error("pin 5 drives high or pulls up");
    AST_LOW_NO_PULL: assert property ((pull_on & ~pad_oe_n & ~pad_out) == 8'h00)
        else $error("pull-up on while driving low");
    AST_WDOG_NEEDS_SLOW: assert property (wdog_en |-> slow_osc_en)
        else $error("watchdog on with slow oscillator off");
    AST_VECTOR_ZERO: assert property (reset_vector == 10'h000)
        else $error("restart address not zero");
    AST_WO_READ_ZERO: assert property (io_rd && (io_addr == `IOSR_A_TRIM ||
        io_addr == `IOSR_A_MISC) |=> io_rdata == 8'h00)
        else $error("write-only register read not zero");
    AST_FLAGS_HIGH_ONES: assert property (io_rd && io_addr == `IOSR_A_FLAGS |=>
        io_rdata[7:4] == 4'hf)
        else $error("flag upper nibble not ones");
    AST_PRESCALE_64: assert property (s_pre64_wr |-> ##[1:2] timer_prescale_max == 6'h3f)
        else $error("prescale 64 not applied");
    AST_REQ_HELD: assert property ($fell(irq_pin) |-> $past(io_wr) &&
        ($past(io_addr) == `IOSR_A_INTRQ || $past(io_addr) == `IOSR_A_INTEN))
        else $error("pin request dropped without a write");
    AST_WAKE_TIME: assert property (wake_count == 11'd1024 || wake_count == 11'd128)
        else $error("wake count not a legal value");
endmodule

// ==== bench/iosr_core_model.sv ====
`timescale 1ns/1ps
`include "iosr_regs.vh"
// ****************************************
// processor core model on the io bus
// ****************************************
module iosr_core_model (
    input wire clk,
    output logic [5:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire [7:0] io_rdata
);
    // idle bus: strobes low, address and data scrambled
    initial begin
        io_addr = 6'h3f;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h5a;
    end
    // one-cycle write between two falling edges; no strobe for the trim address, stack pointer bit 0 cleared
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = (a == `IOSR_A_SP) ? (d & 8'hfe) : d;
        io_wr = (a != `IOSR_A_TRIM);
        @(negedge clk);
        io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~io_wdata;
    endtask
    // one-cycle read, data taken half a cycle after the read edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        io_addr = ~a;
        d = io_rdata;
    endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`include "iosr_regs.vh"
// ****************************************
// register bank testbench
// ****************************************
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] pad_in = 8'h00; // pad levels seen by the block
    logic sleep_save = 1'b0; // core sleep levels
    logic sleep_deep = 1'b0;
    logic [15:0] tcount = 16'h0000; // timer counter value
    logic [3:0] flg_in = 4'h0; // alu flag update
    logic flg_we = 1'b0;
    logic [15:0] ck_ok = 16'h1bc3; // legal clock codes, one bit per code
    logic [7:0] src_ok = 8'hd2; // legal timer sources, one bit per code
    wire [5:0] io_addr;
    wire io_wr, io_rd, irq_pin, ext_reset_sel, clk_sel_valid, wdog_en, timer_tick_en;
    wire irq_timer, wake_event, fast_osc_en, slow_osc_en, bandgap_off, lvr_disable;
    wire [3:0] alu_flags_out;
    wire [5:0] fast_osc_trim;
    wire [7:0] io_wdata, io_rdata, pad_out, pad_oe_n, pull_on;
    wire [3:0] clk_sel_code;
    wire [2:0] timer_src;
    wire [5:0] timer_prescale_max;
    wire [15:0] wdog_timeout;
    wire [10:0] wake_count;
    int comparisons = 0;
    int n_mismatch = 0;
    logic [15:0] wt [4] = '{16'd2048, 16'd4096, 16'd16384, 16'd256};
    // system clock, 5 ns period
    always #2.5 clk = ~clk;
    iosr_core_model u_core (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata));
    iosr_top u_dut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .alu_flags_in(flg_in),
        .alu_flags_we(flg_we), .alu_flags_out(alu_flags_out), .sleep_save(sleep_save),
        .sleep_deep(sleep_deep), .timer_count(tcount), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pull_on(pull_on), .ext_reset_sel(ext_reset_sel),
        .reset_vector(), .irq_timer(irq_timer), .irq_pin(irq_pin), .wake_event(wake_event),
        .clk_sel_code(clk_sel_code), .clk_sel_valid(clk_sel_valid), .fast_osc_en(fast_osc_en),
        .slow_osc_en(slow_osc_en), .wdog_en(wdog_en), .fast_osc_trim(fast_osc_trim),
        .bandgap_off(bandgap_off), .lvr_disable(lvr_disable), .timer_src(timer_src),
        .timer_tick_en(timer_tick_en), .timer_prescale_max(timer_prescale_max),
        .wdog_timeout(wdog_timeout), .wake_count(wake_count));
    // compare one value and count it
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // read a register and compare
    task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_core.rd(a, d);
        chk(nm, {8'h00, d}, {8'h00, exp});
    endtask
    // counts, verdict and end of run
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // bounded wait for the pin request, or a quiet check that none came
    task automatic irq_wait(input logic exp);
        int i;
        for (i = 0; i < 8 && irq_pin !== exp; i++) @(negedge clk);
        if (!exp) repeat (4) @(negedge clk);
        chk("irq_pin", {15'h0, irq_pin}, {15'h0, exp});
        if (irq_pin !== exp) final_report;
    endtask
    initial begin
        int i;
        logic [3:0] c;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        // register defaults
        rchk("clock_mode", `IOSR_A_CLKMD, 8'hf6);
        rchk("alu_flags", `IOSR_A_FLAGS, 8'hf0);
        rchk("direction", `IOSR_A_PDIR, 8'h00);
        rchk("pullup", `IOSR_A_PPULL, 8'h00);
        rchk("wake_enable", `IOSR_A_WAKE, 8'h00);
        rchk("unmapped", 6'h20, 8'h00);
        chk("pad_oe_n", {8'h00, pad_oe_n}, 16'h00ff);
        u_core.wr(`IOSR_A_FLAGS, 8'h0a);
        rchk("alu_flags", `IOSR_A_FLAGS, 8'hfa);
        u_core.wr(`IOSR_A_SP, 8'h41);
        rchk("stack_pointer", `IOSR_A_SP, 8'h40);
        u_core.wr(`IOSR_A_TRIM, 8'h15);
        rchk("trim", `IOSR_A_TRIM, 8'h00);
        u_core.wr(`IOSR_A_BGPC, 8'hff);
        chk("bandgap_trim", {9'h0, bandgap_off, fast_osc_trim}, 16'h0040);
        $display("test defaults done");
        // port pins, pulls and read-back
        u_core.wr(`IOSR_A_PPULL, 8'hff);
        u_core.wr(`IOSR_A_PDATA, 8'ha5);
        u_core.wr(`IOSR_A_PDIR, 8'hff);
        chk("pad_oe_n", {8'h00, pad_oe_n & 8'hdf}, 16'h0000);
        chk("pull_on", {8'h00, pull_on}, 16'h0085);
        rchk("port_data", `IOSR_A_PDATA, 8'ha5);
        pad_in = 8'h3c;
        u_core.wr(`IOSR_A_PDIR, 8'h0f);
        chk("pull_on", {8'h00, pull_on}, 16'h00d5);
        rchk("port_data", `IOSR_A_PDATA, 8'h35);
        $display("test port done");
        // pin 0 requests: both edges, rising only, input disabled
        u_core.wr(`IOSR_A_PDIR, 8'h00);
        pad_in = 8'h00;
        u_core.wr(`IOSR_A_INTRQ, 8'h00);
        u_core.wr(`IOSR_A_INTEN, 8'h01);
        pad_in = 8'h01;
        irq_wait(1'b1);
        pad_in = 8'h00;
        rchk("request", `IOSR_A_INTRQ, 8'h01);
        u_core.wr(`IOSR_A_INTRQ, 8'h00);
        irq_wait(1'b0);
        u_core.wr(`IOSR_A_EDGE, 8'h01);
        pad_in = 8'h01;
        irq_wait(1'b1);
        u_core.wr(`IOSR_A_INTRQ, 8'h00);
        pad_in = 8'h00;
        irq_wait(1'b0);
        u_core.wr(`IOSR_A_WAKE, 8'h00);
        pad_in = 8'h01;
        irq_wait(1'b0);
        $display("test requests done");
        // every clock code, slow enable and shared pin choice
        for (i = 0; i < 16; i++) begin
            c = i[3:0];
            u_core.wr(`IOSR_A_CLKMD, {c[2:0], ~c[0], c[3], c[0], 1'b1, c[1]});
            @(negedge clk);
            chk("clk_sel", {7'h0, c, clk_sel_valid, fast_osc_en, slow_osc_en, wdog_en,
                ext_reset_sel}, {7'h0, c, ck_ok[c], ~c[0], c[0], c[0], c[1]});
        end
        // timer source and prescale, watchdog and wake timing
        for (i = 0; i < 8; i++) begin
            u_core.wr(`IOSR_A_TMODE, {i[2:0], i[1:0], 3'b000});
            u_core.wr(`IOSR_A_MISC, {2'b00, i[0], 2'b00, i[2], i[1:0]});
            @(negedge clk);
            chk("timer_src", {12'h0, timer_src, timer_tick_en},
                {12'h0, i[2:0], src_ok[i[2:0]]});
            chk("lvr_disable", {15'h0, lvr_disable}, {15'h0, i[2]});
            chk("prescale", {10'h0, timer_prescale_max}, (16'h1 << (2 * i[1:0])) - 1);
            chk("wdog_timeout", wdog_timeout, wt[i[1:0]]);
            chk("wake_count", {5'h0, wake_count}, i[0] ? 16'd128 : 16'd1024);
        end
        rchk("misc", `IOSR_A_MISC, 8'h00);
        $display("test modes done");
        // timer event from counter bit 8, wake sources per sleep state
        u_core.wr(`IOSR_A_INTEN, 8'h04);
        sleep_deep = 1'b1;
        tcount = 16'h0100;
        @(negedge clk);
        chk("irq_timer", {15'h0, irq_timer}, 16'h0001);
        chk("wake_deep_timer", {15'h0, wake_event}, 16'h0000);
        u_core.wr(`IOSR_A_INTRQ, 8'h00);
        chk("irq_timer", {15'h0, irq_timer}, 16'h0000);
        u_core.wr(`IOSR_A_EDGE, 8'h10);
        sleep_deep = 1'b0;
        sleep_save = 1'b1;
        tcount = 16'h0000;
        @(negedge clk);
        chk("wake_save_timer", {15'h0, wake_event}, 16'h0001);
        @(negedge clk);
        chk("wake_pulse", {15'h0, wake_event}, 16'h0000);
        u_core.wr(`IOSR_A_WAKE, 8'h80);
        sleep_save = 1'b0;
        sleep_deep = 1'b1;
        pad_in = 8'h41;
        @(negedge clk);
        chk("wake_masked_pin", {15'h0, wake_event}, 16'h0000);
        pad_in = 8'hc1;
        @(negedge clk);
        chk("wake_deep_pin", {15'h0, wake_event}, 16'h0001);
        // alu flag update path
        sleep_deep = 1'b0;
        flg_in = 4'h5;
        flg_we = 1'b1;
        @(negedge clk);
        flg_we = 1'b0;
        chk("alu_flags_out", {12'h0, alu_flags_out}, 16'h0005);
        rchk("alu_flags", `IOSR_A_FLAGS, 8'hf5);
        $display("test events done");
        final_report;
    end
endmodule
bind iosr_top iosr_checker u_chk (.clk(clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pull_on(pull_on),
    .reset_vector(reset_vector), .irq_pin(irq_pin), .slow_osc_en(slow_osc_en),
    .wdog_en(wdog_en), .timer_prescale_max(timer_prescale_max), .wake_count(wake_count));
